// ### design/fp_bank_pkg.sv
package fp_bank_pkg;

  // ----------------------------------------------------------------
  // Bank geometry
  // ----------------------------------------------------------------
  localparam int NUM_DREGS = 32;
  localparam int DREG_W = 64;
  localparam int SREG_W = 32;
  localparam int QREG_W = 128;
  localparam logic [63:0] DREG_RESET = 64'h0;

  // ----------------------------------------------------------------
  // Short-vector control
  // ----------------------------------------------------------------
  localparam logic [3:0] SP_MAX_ITER = 4'h8;
  localparam logic [3:0] DP_MAX_ITER = 4'h4;
  localparam logic [2:0] LEN_SCALAR = 3'h0;
  localparam logic [1:0] STRIDE_ONE = 2'h0;
  localparam logic [1:0] STRIDE_TWO = 2'h3;
  localparam logic [1:0] SP_SCALAR_BANK = 2'h0;
  localparam logic [2:0] DP_SCALAR_BANK = 3'h0;
  localparam logic [2:0] DP_ALT_SCALAR_BANK = 3'h4;
  localparam logic [5:0] LS_LAST_INDEX = 6'h1f;

  typedef enum logic [1:0] {
    VIEW_S,
    VIEW_D,
    VIEW_Q
  } view_t;

  // Bank base kept, offset advanced modulo the bank size
  function automatic logic [4:0] vec_index(input logic dp, input logic [4:0] r,
                                           input logic [2:0] step);
    logic [1:0] dp_ofs;
    logic [2:0] sp_ofs;
    dp_ofs = r[1:0] + step[1:0];
    sp_ofs = r[2:0] + step;
    if (dp) begin
      return {r[4:2], dp_ofs};
    end
    return {r[4:3], sp_ofs};
  endfunction

  // Destination in a bank that forces a single scalar iteration
  function automatic logic in_scalar_bank(input logic dp, input logic [4:0] r);
    if (dp) begin
      return (r[4:2] == DP_SCALAR_BANK) || (r[4:2] == DP_ALT_SCALAR_BANK);
    end
    return r[4:3] == SP_SCALAR_BANK;
  endfunction

endpackage

// ### design/vec_addr_seq.sv
`timescale 1ns/1ns
module vec_addr_seq
  import fp_bank_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic start, // Begin a data-processing op
  input wire logic dp, // Double precision when high
  input wire logic [2:0] vector_length_field, // Iterations minus one
  input wire logic [1:0] stride_field, // Stride select
  input wire logic [4:0] destination_operand, // Destination start index
  input wire logic [4:0] first_source_operand, // First source start index
  input wire logic [4:0] second_source_operand, // Second source start index
  output logic ready, // Idle, start accepted
  output logic iter_valid, // One iteration this cycle
  output logic iter_dp, // Precision of iteration
  output logic [4:0] iter_dest, // Destination index
  output logic [4:0] iter_n, // First source index
  output logic [4:0] iter_m, // Second source index
  output logic iter_last // Final iteration
);

  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;

  seq_state_t state_q;
  logic [2:0] iter_q;
  logic [3:0] total_q;
  logic dp_q;
  logic stride2_q;
  logic m_scalar_q;
  logic [4:0] d_q;
  logic [4:0] n_q;
  logic [4:0] m_q;
  logic scalar_d;
  logic [3:0] total_d;
  logic [3:0] len_plus1;
  logic [2:0] step;

  // ----------------------------------------------------------------
  // Iteration count
  // ----------------------------------------------------------------
  always_comb begin
    len_plus1 = {1'b0, vector_length_field} + 4'h1;
    scalar_d = (vector_length_field == LEN_SCALAR) ||
               in_scalar_bank(dp, destination_operand);
    if (scalar_d) begin
      total_d = 4'h1;
    end else if (dp && (len_plus1 > DP_MAX_ITER)) begin
      // Overlong double lengths are clipped rather than trapped
      total_d = DP_MAX_ITER;
    end else begin
      total_d = len_plus1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= SEQ_IDLE;
      iter_q <= 3'h0;
      total_q <= 4'h1;
      dp_q <= 1'b0;
      stride2_q <= 1'b0;
      m_scalar_q <= 1'b0;
      d_q <= 5'h0;
      n_q <= 5'h0;
      m_q <= 5'h0;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (start) begin
            state_q <= SEQ_RUN;
            iter_q <= 3'h0;
            total_q <= total_d;
            dp_q <= dp;
            stride2_q <= (stride_field == STRIDE_TWO);
            m_scalar_q <= in_scalar_bank(dp, second_source_operand) && !scalar_d;
            d_q <= destination_operand;
            n_q <= first_source_operand;
            m_q <= second_source_operand;
          end
        end
        SEQ_RUN: begin
          if ({1'b0, iter_q} == total_q - 4'h1) begin
            state_q <= SEQ_IDLE;
          end else begin
            iter_q <= iter_q + 3'h1;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Circular addressing
  // ----------------------------------------------------------------
  assign step = stride2_q ? {iter_q[1:0], 1'b0} : iter_q;
  assign ready = (state_q == SEQ_IDLE);
  assign iter_valid = (state_q == SEQ_RUN);
  assign iter_dp = dp_q;
  assign iter_dest = vec_index(dp_q, d_q, step);
  assign iter_n = vec_index(dp_q, n_q, step);
  assign iter_m = m_scalar_q ? m_q : vec_index(dp_q, m_q, step);
  assign iter_last = iter_valid && ({1'b0, iter_q} == total_q - 4'h1);

endmodule

// ### design/fp_simd_register_bank.sv
`timescale 1ns/1ns
module fp_simd_register_bank
  import fp_bank_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic slot0_valid, // Issue slot 0 request
  input wire logic slot0_write, // Slot 0 write when high
  input wire view_t slot0_view, // Slot 0 register view
  input wire logic [4:0] slot0_index, // Slot 0 register number
  input wire logic [127:0] slot0_wdata, // Slot 0 write data
  output logic [127:0] slot0_rdata, // Slot 0 read data
  output logic slot0_rvalid, // Slot 0 read data valid
  input wire logic slot1_valid, // Issue slot 1 request
  input wire logic slot1_write, // Slot 1 write when high
  input wire view_t slot1_view, // Slot 1 register view
  input wire logic [4:0] slot1_index, // Slot 1 register number
  input wire logic [127:0] slot1_wdata, // Slot 1 write data
  output logic [127:0] slot1_rdata, // Slot 1 read data
  output logic slot1_rvalid, // Slot 1 read data valid
  input wire logic core_to_coproc_transfer, // Word move into a single register
  input wire logic [4:0] c2p_index, // Single register for move in
  input wire logic [31:0] c2p_data, // Word moved in
  input wire logic coproc_to_core_transfer, // Word move out request
  input wire logic [4:0] p2c_index, // Single register for move out
  output logic [31:0] p2c_data, // Word moved out
  output logic p2c_valid, // Moved-out word valid
  input wire logic ls_start, // Start multiple load/store
  input wire logic ls_write, // Load into bank when high
  input wire logic ls_dp, // Double registers when high
  input wire logic [4:0] ls_base, // First register
  input wire logic [5:0] ls_count, // Registers to transfer
  input wire logic ls_beat, // One register this cycle
  input wire logic [63:0] ls_wdata, // Loaded data
  output logic ls_busy, // Transfer in progress
  output logic [63:0] ls_rdata, // Stored data
  output logic ls_rvalid, // Stored data valid
  input wire logic vec_start, // Start data-processing op
  input wire logic vec_dp, // Double precision op
  input wire logic [2:0] vector_length_field, // Iterations minus one
  input wire logic [1:0] vec_stride, // Stride select
  input wire logic [4:0] destination_operand, // Destination start
  input wire logic [4:0] first_source_operand, // First source start
  input wire logic [4:0] second_source_operand, // Second source start
  output logic vec_ready, // Sequencer idle
  output logic op_valid, // Operands presented
  output logic op_dp, // Operand precision
  output logic [4:0] op_dest, // Destination for this iteration
  output logic [63:0] op_n_data, // First source value
  output logic [63:0] op_m_data, // Second source value
  output logic op_last, // Last iteration
  input wire logic res_valid, // Result write back
  input wire logic res_dp, // Result precision
  input wire logic [4:0] res_index, // Result register
  input wire logic [63:0] res_data // Result value
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Doubleword array is the only storage; other views are index maps
  logic [DREG_W-1:0] bank_q [NUM_DREGS];
  logic [DREG_W-1:0] bank_d [NUM_DREGS];

  logic seq_valid;
  logic seq_dp;
  logic [4:0] seq_dest;
  logic [4:0] seq_n;
  logic [4:0] seq_m;
  logic seq_last;
  logic [5:0] ls_idx_q;
  logic [5:0] ls_left_q;
  logic ls_write_q;
  logic ls_dp_q;
  logic ls_active;
  logic ls_go;
  logic slot0_rd;
  logic slot1_rd;
  logic slot0_wr;
  logic slot1_wr;
  logic ls_rd_go;
  logic ls_wr_go;

  // Single register n is a half of double n>>1
  function automatic logic [SREG_W-1:0] rd_single(input logic [4:0] idx);
    logic [DREG_W-1:0] dw;
    dw = bank_q[idx[4:1]];
    return idx[0] ? dw[63:32] : dw[31:0];
  endfunction

  function automatic logic [DREG_W-1:0] rd_elem(input logic dp, input logic [4:0] idx);
    if (dp) begin
      return bank_q[idx];
    end
    return {32'h0, rd_single(idx)};
  endfunction

  function automatic logic [QREG_W-1:0] rd_view(input view_t v, input logic [4:0] idx);
    case (v)
      VIEW_Q: return {bank_q[{idx[3:0], 1'b1}], bank_q[{idx[3:0], 1'b0}]};
      VIEW_D: return {64'h0, bank_q[idx]};
      default: return {96'h0, rd_single(idx)};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Write merging
  // ----------------------------------------------------------------
  // Writes merge in order, so two halves of one double both land.
  // Priority: move-in, load, result, slot 0, slot 1 (last wins).
  task automatic put_single(input logic [4:0] idx, input logic [31:0] val);
    if (idx[0]) begin
      bank_d[idx[4:1]][63:32] = val;
    end else begin
      bank_d[idx[4:1]][31:0] = val;
    end
  endtask

  task automatic put_view(input view_t v, input logic [4:0] idx, input logic [127:0] val);
    case (v)
      VIEW_Q: begin
        bank_d[{idx[3:0], 1'b0}] = val[63:0];
        bank_d[{idx[3:0], 1'b1}] = val[127:64];
      end
      VIEW_D: bank_d[idx] = val[63:0];
      default: put_single(idx, val[31:0]);
    endcase
  endtask

  assign slot0_wr = slot0_valid && slot0_write;
  assign slot1_wr = slot1_valid && slot1_write;
  assign ls_wr_go = ls_go && ls_write_q;

  always_comb begin
    for (int i = 0; i < NUM_DREGS; i++) begin
      bank_d[i] = bank_q[i];
    end
    if (core_to_coproc_transfer) begin
      put_single(c2p_index, c2p_data);
    end
    if (ls_wr_go) begin
      if (ls_dp_q) begin
        bank_d[ls_idx_q[4:0]] = ls_wdata;
      end else begin
        put_single(ls_idx_q[4:0], ls_wdata[31:0]);
      end
    end
    if (res_valid) begin
      if (res_dp) begin
        bank_d[res_index] = res_data;
      end else begin
        put_single(res_index, res_data[31:0]);
      end
    end
    if (slot0_wr) begin
      put_view(slot0_view, slot0_index, slot0_wdata);
    end
    if (slot1_wr) begin
      put_view(slot1_view, slot1_index, slot1_wdata);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_DREGS; i++) begin
        bank_q[i] <= DREG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_DREGS; i++) begin
        bank_q[i] <= bank_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Issue slot reads
  // ----------------------------------------------------------------
  // Both slots read in the same cycle; data shows the bank before writes
  assign slot0_rd = slot0_valid && !slot0_write;
  assign slot1_rd = slot1_valid && !slot1_write;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot0_rvalid <= 1'b0;
      slot1_rvalid <= 1'b0;
    end else begin
      slot0_rvalid <= slot0_rd;
      slot1_rvalid <= slot1_rd;
    end
  end

  // Data holds until the next read of its slot
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot0_rdata <= 128'h0;
    end else if (slot0_rd) begin
      slot0_rdata <= rd_view(slot0_view, slot0_index);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot1_rdata <= 128'h0;
    end else if (slot1_rd) begin
      slot1_rdata <= rd_view(slot1_view, slot1_index);
    end
  end

  // ----------------------------------------------------------------
  // Word move out
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      p2c_valid <= 1'b0;
    end else begin
      p2c_valid <= coproc_to_core_transfer;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      p2c_data <= 32'h0;
    end else if (coproc_to_core_transfer) begin
      p2c_data <= rd_single(p2c_index);
    end
  end

  // ----------------------------------------------------------------
  // Multiple load/store
  // ----------------------------------------------------------------
  // Ends early at the top of the file instead of wrapping
  assign ls_active = (ls_left_q != 6'h0);
  assign ls_busy = ls_active;
  assign ls_go = ls_active && ls_beat;
  assign ls_rd_go = ls_go && !ls_write_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ls_idx_q <= 6'h0;
      ls_left_q <= 6'h0;
      ls_write_q <= 1'b0;
      ls_dp_q <= 1'b0;
    end else if (!ls_active) begin
      if (ls_start) begin
        ls_idx_q <= {1'b0, ls_base};
        ls_left_q <= ls_count;
        ls_write_q <= ls_write;
        ls_dp_q <= ls_dp;
      end
    end else if (ls_go) begin
      ls_idx_q <= ls_idx_q + 6'h1;
      if (ls_idx_q == LS_LAST_INDEX) begin
        ls_left_q <= 6'h0;
      end else begin
        ls_left_q <= ls_left_q - 6'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ls_rvalid <= 1'b0;
    end else begin
      ls_rvalid <= ls_rd_go;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ls_rdata <= 64'h0;
    end else if (ls_rd_go) begin
      ls_rdata <= rd_elem(ls_dp_q, ls_idx_q[4:0]);
    end
  end

  // ----------------------------------------------------------------
  // Short-vector operand fetch
  // ----------------------------------------------------------------
  vec_addr_seq u_seq (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(vec_start),
    .dp(vec_dp),
    .vector_length_field(vector_length_field),
    .stride_field(vec_stride),
    .destination_operand(destination_operand),
    .first_source_operand(first_source_operand),
    .second_source_operand(second_source_operand),
    .ready(vec_ready),
    .iter_valid(seq_valid),
    .iter_dp(seq_dp),
    .iter_dest(seq_dest),
    .iter_n(seq_n),
    .iter_m(seq_m),
    .iter_last(seq_last)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      op_valid <= 1'b0;
      op_last <= 1'b0;
    end else begin
      op_valid <= seq_valid;
      op_last <= seq_last;
    end
  end

  // Double indices 16-31 take banks 4-7 through the same index map
  // No result bypass: an operand written by an earlier iteration reads stale
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      op_dp <= 1'b0;
      op_dest <= 5'h0;
      op_n_data <= 64'h0;
      op_m_data <= 64'h0;
    end else if (seq_valid) begin
      op_dp <= seq_dp;
      op_dest <= seq_dest;
      op_n_data <= rd_elem(seq_dp, seq_n);
      op_m_data <= rd_elem(seq_dp, seq_m);
    end
  end

endmodule

// ### verification/simd_bank_checker.sv
`timescale 1ns/1ns
module simd_bank_checker
  import fp_bank_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic slot0_valid, // Slot 0 request
  input wire logic slot0_write, // Slot 0 write
  input wire logic slot0_rvalid, // Slot 0 data
  input wire logic slot1_valid, // Slot 1 request
  input wire logic slot1_write, // Slot 1 write
  input wire logic slot1_rvalid, // Slot 1 data
  input wire logic coproc_to_core_transfer, // Move out
  input wire logic p2c_valid, // Moved word
  input wire logic ls_busy, // Transfer running
  input wire logic ls_beat, // Beat
  input wire logic ls_write, // Load
  input wire logic ls_rvalid, // Stored data
  input wire logic vec_start, // Op start
  input wire logic [2:0] vector_length_field, // Length
  input wire logic vec_ready, // Idle
  input wire logic op_valid, // Iteration
  input wire logic op_dp, // Precision
  input wire logic [4:0] op_dest, // Destination
  input wire logic op_last // Last iteration
);
  // ----------------------------------------------------------------
  // Iterations seen so far in the running op
  // ----------------------------------------------------------------
  logic [3:0] cnt_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
    end else if (op_valid) begin
      cnt_q <= op_last ? 4'h0 : cnt_q + 4'h1;
    end
  end

  // Transfer direction as the block latched it at start
  logic ls_wr_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ls_wr_q <= 1'b0;
    end else if (!ls_busy) begin
      ls_wr_q <= ls_write;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_take;
    vec_start && vec_ready;
  endsequence
  sequence s_first;
    ##2 op_valid;
  endsequence

  a_slot0_rd: assert property (
    slot0_valid && !slot0_write |=> slot0_rvalid) else $error("slot0 read lost");
  a_slot1_rd: assert property (
    slot1_valid && !slot1_write |=> slot1_rvalid) else $error("slot1 read lost");
  a_move_out: assert property (
    coproc_to_core_transfer |=> p2c_valid) else $error("move-out word lost");
  a_vec_first: assert property (
    s_take |-> s_first) else $error("first iteration late");
  a_scalar_len: assert property (
    s_take ##0 (vector_length_field == LEN_SCALAR) |-> ##2 (op_valid && op_last))
    else $error("zero length not scalar");
  a_bank_hold: assert property (
    op_valid && $past(op_valid) |-> (op_dp ? op_dest[4:2] == $past(op_dest[4:2])
                                            : op_dest[4:3] == $past(op_dest[4:3])))
    else $error("destination left its bank");
  a_iter_max: assert property (
    op_valid |-> cnt_q < (op_dp ? 4'h4 : 4'h8)) else $error("too many iterations");
  a_ls_rd: assert property (
    ls_beat && ls_busy && !ls_wr_q |=> ls_rvalid) else $error("store beat lost");
endmodule

bind fp_simd_register_bank simd_bank_checker u_chk (.clk_sys, .reset_n, .slot0_valid,
  .slot0_write, .slot0_rvalid, .slot1_valid, .slot1_write, .slot1_rvalid,
  .coproc_to_core_transfer, .p2c_valid, .ls_busy, .ls_beat, .ls_write, .ls_rvalid,
  .vec_start, .vector_length_field, .vec_ready, .op_valid, .op_dp, .op_dest, .op_last);

// ### verification/exec_unit_model.sv
`timescale 1ns/1ns
module exec_unit_model #(
  parameter int LAT = 1
) (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic op_valid, // Operands presented
  input wire logic op_dp, // Precision
  input wire logic [4:0] op_dest, // Destination
  input wire logic [63:0] op_n_data, // First source
  input wire logic [63:0] op_m_data, // Second source
  output logic res_valid, // Result write
  output logic res_dp, // Result precision
  output logic [4:0] res_index, // Result register
  output logic [63:0] res_data // Result value
);
  // ----------------------------------------------------------------
  // Adder pipeline, LAT cycles deep
  // ----------------------------------------------------------------
  logic v_q [LAT];
  logic p_q [LAT];
  logic [4:0] i_q [LAT];
  logic [63:0] d_q [LAT];
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < LAT; k++) begin
        v_q[k] <= 1'b0;
      end
    end else begin
      v_q[0] <= op_valid;
      p_q[0] <= op_dp;
      i_q[0] <= op_dest;
      d_q[0] <= op_n_data + op_m_data;
      for (int k = 1; k < LAT; k++) begin
        v_q[k] <= v_q[k-1];
        p_q[k] <= p_q[k-1];
        i_q[k] <= i_q[k-1];
        d_q[k] <= d_q[k-1];
      end
    end
  end
  // Idle index and data lines flip so stale values never look valid
  assign res_valid = v_q[LAT-1];
  assign res_dp = p_q[LAT-1];
  assign res_index = res_valid ? i_q[LAT-1] : ~i_q[LAT-1];
  assign res_data = res_valid ? d_q[LAT-1] : ~d_q[LAT-1];
endmodule

// ### verification/tb.sv
`timescale 1ns/1ns
module tb;
  import fp_bank_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic slot0_valid, slot0_write, slot1_valid, slot1_write, ls_start, ls_write, ls_dp;
  logic core_to_coproc_transfer, coproc_to_core_transfer, ls_beat, vec_start, vec_dp;
  view_t slot0_view, slot1_view;
  logic [4:0] slot0_index, slot1_index, c2p_index, p2c_index, ls_base, op_dest, res_index;
  logic [4:0] destination_operand, first_source_operand, second_source_operand;
  logic [127:0] slot0_wdata, slot1_wdata, slot0_rdata, slot1_rdata;
  logic [31:0] c2p_data, p2c_data;
  logic [5:0] ls_count;
  logic [63:0] ls_wdata, ls_rdata, op_n_data, op_m_data, res_data;
  logic [2:0] vector_length_field;
  logic [1:0] vec_stride;
  logic slot0_rvalid, slot1_rvalid, p2c_valid, ls_busy, ls_rvalid, vec_ready;
  logic op_valid, op_dp, op_last, res_valid, res_dp;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;

  fp_simd_register_bank DUT (.clk_sys, .reset_n, .slot0_valid, .slot0_write, .slot0_view,
    .slot0_index, .slot0_wdata, .slot0_rdata, .slot0_rvalid, .slot1_valid, .slot1_write,
    .slot1_view, .slot1_index, .slot1_wdata, .slot1_rdata, .slot1_rvalid,
    .core_to_coproc_transfer, .c2p_index, .c2p_data, .coproc_to_core_transfer, .p2c_index,
    .p2c_data, .p2c_valid, .ls_start, .ls_write, .ls_dp, .ls_base, .ls_count, .ls_beat,
    .ls_wdata, .ls_busy, .ls_rdata, .ls_rvalid, .vec_start, .vec_dp, .vector_length_field,
    .vec_stride, .destination_operand, .first_source_operand, .second_source_operand,
    .vec_ready, .op_valid, .op_dp, .op_dest, .op_n_data, .op_m_data, .op_last, .res_valid,
    .res_dp, .res_index, .res_data);
  exec_unit_model #(.LAT(2)) u_exec (.clk_sys, .reset_n, .op_valid, .op_dp, .op_dest,
    .op_n_data, .op_m_data, .res_valid, .res_dp, .res_index, .res_data);

  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Preloaded pattern: single k holds k, so double j is {2j+1, 2j}
  function automatic logic [63:0] dval(input int j);
    return {32'(2 * j + 1), 32'(2 * j)};
  endfunction
  function automatic logic [4:0] vidx(input logic dp_i, input logic [4:0] r, input int s);
    return dp_i ? {r[4:2], r[1:0] + s[1:0]} : {r[4:3], r[2:0] + s[2:0]};
  endfunction
  function automatic logic [63:0] opv(input logic dp_i, input logic [4:0] ix);
    return dp_i ? dval(ix) : {59'h0, ix};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic preload();
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      {slot0_valid, slot0_write, slot1_valid, slot1_write} <= 4'hf;
      slot0_index <= 5'(k);
      slot1_index <= 5'(k + 16);
      slot0_wdata <= {64'h0, dval(k)};
      slot1_wdata <= {64'h0, dval(k + 16)};
    end
    @(posedge clk_sys);
    {slot0_valid, slot0_write, slot1_valid, slot1_write} <= 4'h0;
  endtask
  task automatic alias_read();
    for (int k = 0; k < 32; k++) begin
      @(posedge clk_sys);
      {slot0_valid, slot1_valid} <= 2'h3;
      slot0_view <= VIEW_Q;
      slot1_view <= VIEW_S;
      slot0_index <= {1'b0, k[3:0]};
      slot1_index <= 5'(k);
      @(posedge clk_sys);
      {slot0_valid, slot1_valid} <= 2'h0;
      #1;
      chk(slot0_rvalid & slot1_rvalid, 1'b1);
      chk(slot0_rdata, {dval(2 * k[3:0] + 1), dval(2 * k[3:0])});
      chk(slot1_rdata, 128'(k));
    end
  endtask
  task automatic vec_run(input logic dp_i, input logic [2:0] len, input logic [1:0] sc,
      input logic [4:0] d, input logic [4:0] n, input logic [4:0] m, input int iters,
      input logic ms);
    int st;
    st = (sc == 2'h3) ? 2 : 1;
    @(posedge clk_sys);
    vec_start <= 1'b1;
    vec_dp <= dp_i;
    vector_length_field <= len;
    vec_stride <= sc;
    destination_operand <= d;
    first_source_operand <= n;
    second_source_operand <= m;
    @(posedge clk_sys);
    vec_start <= 1'b0;
    for (int i = 0; i < iters; i++) begin
      @(posedge clk_sys);
      #1;
      chk(op_valid, 1'b1);
      chk(op_dp, dp_i);
      chk(op_dest, vidx(dp_i, d, i * st));
      chk(op_n_data, opv(dp_i, vidx(dp_i, n, i * st)));
      chk(op_m_data, opv(dp_i, vidx(dp_i, m, ms ? 0 : i * st)));
      chk(op_last, i == iters - 1);
    end
    @(posedge clk_sys);
    #1;
    chk({op_valid, vec_ready}, 2'h1);
  endtask
  task automatic move_words();
    @(posedge clk_sys);
    core_to_coproc_transfer <= 1'b1;
    c2p_index <= 5'h05;
    c2p_data <= 32'hcafe0005;
    @(posedge clk_sys);
    core_to_coproc_transfer <= 1'b0;
    coproc_to_core_transfer <= 1'b1;
    p2c_index <= 5'h04;
    @(posedge clk_sys);
    coproc_to_core_transfer <= 1'b0;
    slot0_valid <= 1'b1;
    slot0_view <= VIEW_D;
    slot0_index <= 5'h02;
    #1;
    chk({p2c_valid, p2c_data}, {1'b1, 32'h4});
    @(posedge clk_sys);
    slot0_valid <= 1'b0;
    slot1_valid <= 1'b1;
    slot1_index <= 5'h08;
    #1;
    chk(slot0_rdata, {64'h0, 32'hcafe0005, 32'h4});
    @(posedge clk_sys);
    slot1_valid <= 1'b0;
    #1;
    // Wrapped last iteration of the first op wrote 19 + 28 here
    chk(slot1_rdata, 128'h2f);
  endtask
  task automatic store_top();
    @(posedge clk_sys);
    {ls_start, ls_dp} <= 2'h3;
    ls_base <= 5'h1e;
    ls_count <= 6'h04;
    @(posedge clk_sys);
    ls_start <= 1'b0;
    ls_beat <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      if (j == 1) ls_beat <= 1'b0;
      #1;
      chk({ls_rvalid, ls_rdata}, {1'b1, dval(30 + j)});
    end
    chk(ls_busy, 1'b0);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    {slot0_valid, slot0_write, slot1_valid, slot1_write, ls_start, ls_write, ls_dp} = '0;
    {core_to_coproc_transfer, coproc_to_core_transfer, ls_beat, vec_start, vec_dp} = '0;
    {slot0_index, slot1_index, c2p_index, p2c_index, ls_base, ls_count} = '0;
    {destination_operand, first_source_operand, second_source_operand} = '0;
    {slot0_wdata, slot1_wdata, c2p_data, ls_wdata, vector_length_field, vec_stride} = '0;
    slot0_view = VIEW_D;
    slot1_view = VIEW_D;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    preload();
    alias_read();
    vec_run(1'b0, 3'h5, 2'h0, 5'd11, 5'd22, 5'd31, 6, 1'b0);
    vec_run(1'b1, 3'h3, 2'h0, 5'd16, 5'd9, 5'd10, 1, 1'b0);
    vec_run(1'b1, 3'h7, 2'h0, 5'd21, 5'd9, 5'd2, 4, 1'b1);
    vec_run(1'b0, 3'h0, 2'h0, 5'd20, 5'd1, 5'd3, 1, 1'b0);
    vec_run(1'b0, 3'h2, 2'h0, 5'd3, 5'd4, 5'd5, 1, 1'b0);
    vec_run(1'b0, 3'h1, 2'h3, 5'd24, 5'd27, 5'd17, 2, 1'b0);
    move_words();
    store_top();
    wrap_up();
  end
endmodule
